// File: verilog/ddcc_pkg.sv
// Operation
// - lock bit set blocks register writes, except the unlock field and the lock clear
// - unlock: password 0101, then write lock 0
// - bit 13 picks fault-dump address 0x00/0x01
// - bit 12 enables the internal reference
// - two-bit voltage shutdown codes, reset 11
// - current shutdown bit, 1 powers down
// - reset code 1010 fires full reset
// - load bit pulses synchronous output load
// - clear bit pulses output clear
// - fault-dump bit starts dump, self-clears
// - protect bit starts protect, self-clears
// - readback bit reads one nonvolatile row
// - program bit writes settings to nonvolatile
// - restore bit reloads map from nonvolatile
// - bit 15 selects latched window comparator
// - flag clear bit resets comparator outputs
// - margin low/high bits issue margin commands
// - run bit holds waveform generation running
package ddcc_pkg;
    localparam int DDCC_CHANNELS = 2;
    // register addresses on the serial register port
    localparam logic [7:0] DDCC_ADDR_CONFIG = 8'h1f;
    localparam logic [7:0] DDCC_ADDR_GTRIG = 8'h20;
    localparam logic [7:0] DDCC_ADDR_CTRIG = 8'h21;
    localparam logic [15:0] DDCC_CONFIG_RESET = 16'h0fff;
    localparam logic [15:0] DDCC_ZERO16 = 16'h0000;
    // shared configuration fields
    localparam int DDCC_HOLD_BIT = 15;
    localparam int DDCC_LOCK_BIT = 14;
    localparam int DDCC_SNAP_BIT = 13;
    localparam int DDCC_REF_BIT = 12;
    localparam int DDCC_VSHUT_LSB_CH0 = 10;
    localparam int DDCC_VSHUT_LSB_CH1 = 1;
    localparam int DDCC_ISHUT_BIT_CH0 = 9;
    localparam int DDCC_ISHUT_BIT_CH1 = 0;
    localparam logic [7:0] DDCC_SNAP_ADDR0 = 8'h00;
    localparam logic [7:0] DDCC_SNAP_ADDR1 = 8'h01;
    // global trigger fields
    localparam int DDCC_PASS_LSB = 12;
    localparam int DDCC_RST_LSB = 8;
    localparam logic [3:0] DDCC_PASSWORD = 4'h5;
    localparam logic [3:0] DDCC_RESET_CODE = 4'ha;
    localparam int DDCC_LOAD_BIT = 7;
    localparam int DDCC_CLEAR_BIT = 6;
    localparam int DDCC_DUMP_BIT = 4;
    localparam int DDCC_PROT_BIT = 3;
    localparam int DDCC_ROW_BIT = 2;
    localparam int DDCC_PROG_BIT = 1;
    localparam int DDCC_RESTORE_BIT = 0;
    // channel trigger fields, offset from a channel base
    localparam int DDCC_CH0_BASE = 0;
    localparam int DDCC_CH1_BASE = 12;
    localparam int DDCC_FLAG_OFS = 3;
    localparam int DDCC_MLO_OFS = 2;
    localparam int DDCC_MHI_OFS = 1;
    localparam int DDCC_RUN_OFS = 0;
endpackage

// File: verilog/ddcc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module ddcc_regs
    import ddcc_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wdata_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    output logic window_compare_hold_enable_out,
    output logic write_protect_bit_out,
    output logic [7:0] snapshot_read_location_out,
    output logic int_ref_enable_out,
    output logic [3:0] voltage_output_shutdown_out,
    output logic [1:0] current_output_shutdown_out,
    output logic soft_reset_out,
    output logic synchronous_output_load_out,
    output logic output_clear_trigger_out,
    output logic fault_dump_trigger_out,
    output logic protect_trigger_out,
    output logic single_row_readback_out,
    output logic nonvolatile_write_trigger_out,
    output logic nonvolatile_restore_trigger_out,
    output logic [1:0] comparator_flag_clear_out,
    output logic [1:0] lower_margin_trigger_out,
    output logic [1:0] upper_margin_trigger_out,
    output logic [1:0] waveform_run_out
);

    ////////////////////////////////////////////////////////////////////////
    // register bank state
    // the whole bank lives in one packed struct so that the soft reset
    // can return every field to its power-up value in one assignment;
    // the trade-off is that the reset pulse also wipes a read answer
    // that was due in the same cycle, so hosts should not read while
    // they issue the reset code.
    //
    // trigger bits are never stored as levels: a write turns them into
    // one-cycle pulses, which makes them read back as zero for free and
    // avoids a stale pending trigger being replayed by a later write.
    //
    // the unlock field is stored so it can be read back, and the armed
    // flag remembers that the password was the very last write seen.
    typedef struct packed {
        logic [15:0] cfg;       // shared configuration
        logic [3:0] pass;       // last unlock field written
        logic armed;            // password seen, lock may be cleared
        logic [15:0] gpulse;    // one-cycle global trigger pulses
        logic soft_rst;         // one-cycle full reset pulse
        logic [15:0] cpulse;    // one-cycle channel trigger pulses
        logic [1:0] run;        // stored waveform run bits
        logic [15:0] rdata;
        logic rvalid;
    } ddcc_state_type;

    ddcc_state_type st_q;
    ddcc_state_type st_d;

    // address decode, shared by the read and the write paths
    function automatic logic ddcc_hit(input logic [7:0] a, input logic [7:0] target);
        ddcc_hit = (a == target);
    endfunction

    // bit base of a channel within the channel trigger register
    function automatic int ddcc_base(input int ch);
        ddcc_base = (ch == 0) ? DDCC_CH0_BASE : DDCC_CH1_BASE;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state: writes, lock handling, self-clearing triggers, reads
    always_comb begin
        logic locked;
        logic [15:0] ctrig_rd;
        locked = st_q.cfg[DDCC_LOCK_BIT];
        ctrig_rd = DDCC_ZERO16;
        st_d = st_q;
        st_d.gpulse = DDCC_ZERO16;           // pulses last one cycle
        st_d.cpulse = DDCC_ZERO16;
        st_d.soft_rst = 1'b0;
        st_d.rvalid = rd_en_in;
        // only run bits read back; trigger bits always read zero
        for (int c = 0; c < DDCC_CHANNELS; c++) begin
            ctrig_rd[ddcc_base(c) + DDCC_RUN_OFS] = st_q.run[c];
        end
        if (rd_en_in) begin
            if (ddcc_hit(addr_in, DDCC_ADDR_CONFIG)) begin
                st_d.rdata = st_q.cfg;
            end else if (ddcc_hit(addr_in, DDCC_ADDR_GTRIG)) begin
                st_d.rdata = {st_q.pass, 12'h000};
            end else if (ddcc_hit(addr_in, DDCC_ADDR_CTRIG)) begin
                st_d.rdata = ctrig_rd;
            end else begin
                st_d.rdata = DDCC_ZERO16;
            end
        end
        if (wr_en_in) begin
            if (ddcc_hit(addr_in, DDCC_ADDR_GTRIG)) begin
                // the unlock field stays writable so a locked part can be freed
                st_d.pass = wdata_in[DDCC_PASS_LSB +: 4];
                st_d.armed = (wdata_in[DDCC_PASS_LSB +: 4] == DDCC_PASSWORD);
                if (!locked) begin
                    st_d.gpulse[DDCC_LOAD_BIT] = wdata_in[DDCC_LOAD_BIT];
                    st_d.gpulse[DDCC_CLEAR_BIT] = wdata_in[DDCC_CLEAR_BIT];
                    st_d.gpulse[DDCC_DUMP_BIT] = wdata_in[DDCC_DUMP_BIT];
                    st_d.gpulse[DDCC_PROT_BIT] = wdata_in[DDCC_PROT_BIT];
                    st_d.gpulse[DDCC_ROW_BIT] = wdata_in[DDCC_ROW_BIT];
                    st_d.gpulse[DDCC_PROG_BIT] = wdata_in[DDCC_PROG_BIT];
                    st_d.gpulse[DDCC_RESTORE_BIT] = wdata_in[DDCC_RESTORE_BIT];
                end
                // full reset: every register back to its reset value
                if (!locked && wdata_in[DDCC_RST_LSB +: 4] == DDCC_RESET_CODE) begin
                    st_d = '0;
                    st_d.cfg = DDCC_CONFIG_RESET;
                    st_d.soft_rst = 1'b1;
                end
            end else if (ddcc_hit(addr_in, DDCC_ADDR_CONFIG)) begin
                st_d.armed = 1'b0;
                if (!locked) begin
                    st_d.cfg = wdata_in;
                end else if (st_q.armed && !wdata_in[DDCC_LOCK_BIT]) begin
                    // a locked write only clears the lock, other fields kept
                    st_d.cfg[DDCC_LOCK_BIT] = 1'b0;
                end
            end else if (ddcc_hit(addr_in, DDCC_ADDR_CTRIG)) begin
                st_d.armed = 1'b0;
                if (!locked) begin
                    for (int c = 0; c < DDCC_CHANNELS; c++) begin
                        st_d.run[c] = wdata_in[ddcc_base(c) + DDCC_RUN_OFS];
                        st_d.cpulse[ddcc_base(c) + DDCC_FLAG_OFS] =
                            wdata_in[ddcc_base(c) + DDCC_FLAG_OFS];
                        st_d.cpulse[ddcc_base(c) + DDCC_MLO_OFS] =
                            wdata_in[ddcc_base(c) + DDCC_MLO_OFS];
                        st_d.cpulse[ddcc_base(c) + DDCC_MHI_OFS] =
                            wdata_in[ddcc_base(c) + DDCC_MHI_OFS];
                    end
                end
            end else begin
                st_d.armed = 1'b0;   // any other write breaks the sequence
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    // asynchronous reset loads constants only; the configuration word
    // comes up with both outputs shut down, matching the soft reset.
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q <= '0;
            st_q.cfg <= DDCC_CONFIG_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops
    // no logic between the flops and the pins, so downstream blocks in
    // other parts of the device see glitch-free levels and pulses.
    // pulses stand for exactly one clock; consumers must sample every
    // edge and must not expect the request to be held.
    assign rdata_out = st_q.rdata;
    assign rvalid_out = st_q.rvalid;
    assign window_compare_hold_enable_out = st_q.cfg[DDCC_HOLD_BIT];
    assign write_protect_bit_out = st_q.cfg[DDCC_LOCK_BIT];
    assign snapshot_read_location_out =
        st_q.cfg[DDCC_SNAP_BIT] ? DDCC_SNAP_ADDR1 : DDCC_SNAP_ADDR0;
    assign int_ref_enable_out = st_q.cfg[DDCC_REF_BIT];
    assign voltage_output_shutdown_out = {st_q.cfg[DDCC_VSHUT_LSB_CH1 +: 2],
                                          st_q.cfg[DDCC_VSHUT_LSB_CH0 +: 2]};
    assign current_output_shutdown_out = {st_q.cfg[DDCC_ISHUT_BIT_CH1],
                                          st_q.cfg[DDCC_ISHUT_BIT_CH0]};
    assign soft_reset_out = st_q.soft_rst;
    assign synchronous_output_load_out = st_q.gpulse[DDCC_LOAD_BIT];
    assign output_clear_trigger_out = st_q.gpulse[DDCC_CLEAR_BIT];
    assign fault_dump_trigger_out = st_q.gpulse[DDCC_DUMP_BIT];
    assign protect_trigger_out = st_q.gpulse[DDCC_PROT_BIT];
    assign single_row_readback_out = st_q.gpulse[DDCC_ROW_BIT];
    assign nonvolatile_write_trigger_out = st_q.gpulse[DDCC_PROG_BIT];
    assign nonvolatile_restore_trigger_out = st_q.gpulse[DDCC_RESTORE_BIT];

    // per-channel trigger outputs
    // index of each two-bit output is the channel number, so that
    // channel 0 sits in bit 0 regardless of its place in the register.
    genvar gc;
    generate
        for (gc = 0; gc < DDCC_CHANNELS; gc++) begin : g_ch
            localparam int B = (gc == 0) ? DDCC_CH0_BASE : DDCC_CH1_BASE;
            assign comparator_flag_clear_out[gc] = st_q.cpulse[B + DDCC_FLAG_OFS];
            assign lower_margin_trigger_out[gc] = st_q.cpulse[B + DDCC_MLO_OFS];
            assign upper_margin_trigger_out[gc] = st_q.cpulse[B + DDCC_MHI_OFS];
            assign waveform_run_out[gc] = st_q.run[gc];
        end
    endgenerate

endmodule
`default_nettype wire

// File: testbench/ddcc_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ddcc_regs_asserts (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic [15:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic write_protect_bit_out,
    input wire logic [3:0] voltage_output_shutdown_out,
    input wire logic soft_reset_out,
    input wire logic protect_trigger_out,
    input wire logic [1:0] waveform_run_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // trigger write and lock state as seen at the taking edge
    wire logic g_wr = wr_en_in && addr_in == 8'h20;
    wire logic lk = write_protect_bit_out;
    ////////////////////////////////////////
    a_lock_keeps_cfg: assert property (lk && wr_en_in && addr_in == 8'h1f |=>
        $stable(voltage_output_shutdown_out)) else $error("config moved while locked");
    a_lock_no_fire: assert property (lk && g_wr |=>
        !protect_trigger_out && !soft_reset_out) else $error("trigger fired while locked");
    a_protect_cause: assert property (protect_trigger_out |->
        $past(g_wr) && $past(wdata_in[3])) else $error("protect pulse without request");
    a_protect_fires: assert property (!lk && g_wr && wdata_in[3] &&
        wdata_in[11:8] != 4'ha |=> protect_trigger_out) else $error("protect pulse missing");
    a_soft_reset: assert property (!lk && g_wr && wdata_in[11:8] == 4'ha |=> soft_reset_out
        && voltage_output_shutdown_out == 4'hf && waveform_run_out == 2'b00) else $error("reset");
    a_reset_code: assert property (soft_reset_out |->
        $past(g_wr) && $past(wdata_in[11:8]) == 4'ha) else $error("reset without its code");
    a_trig_reads_zero: assert property (rd_en_in && addr_in == 8'h21 |=>
        rvalid_out && (rdata_out & 16'heffe) == 16'h0000) else $error("trigger read not zero");
    a_run_level: assert property (!lk && wr_en_in && addr_in == 8'h21 |=>
        waveform_run_out == {$past(wdata_in[12]), $past(wdata_in[0])}) else $error("run level");
endmodule
bind ddcc_regs ddcc_regs_asserts chk_u (.clk_in, .resetn_in, .wr_en_in, .rd_en_in, .addr_in,
    .wdata_in, .rdata_out, .rvalid_out, .write_protect_bit_out, .voltage_output_shutdown_out,
    .soft_reset_out, .protect_trigger_out, .waveform_run_out);
`default_nettype wire

// File: testbench/ddcc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module ddcc_host_model (
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    input wire logic rvalid_in,
    output logic wr_en_out,
    output logic rd_en_out,
    output logic [7:0] addr_out,
    output logic [15:0] wdata_out
);
    initial begin
        {wr_en_out, rd_en_out, addr_out, wdata_out} = '0;
    end
    ////////////////////////////////////////
    // driven after the falling edge, taken at the next rising edge; idle bus inverted
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_in);
        {wr_en_out, addr_out, wdata_out} = {1'b1, a, d};
        @(negedge clk_in);
        {wr_en_out, addr_out, wdata_out} = {1'b0, ~a, ~d};
    endtask
    // answer is registered at the taking edge, so sample it at the next falling edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
        @(negedge clk_in);
        {rd_en_out, addr_out} = {1'b1, a};
        @(negedge clk_in);
        {d, v} = {rdata_in, rvalid_in};
        {rd_en_out, addr_out} = {1'b0, ~a};
    endtask
    // password must be followed by the lock clear with no other write in between
    task automatic unlock(input logic [15:0] cfg);
        wr(8'h20, 16'h5000);
        wr(8'h1f, cfg & 16'hbfff);
    endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
    logic clk_in, resetn_in, wr_en, rd_en, rvalid, hold, lock, ref_en, srst, v;
    logic [7:0] addr, snap;
    logic [15:0] wdata, rdata, d, w;
    logic [3:0] vsh;
    logic [6:0] gp;
    logic [1:0] ish, fc, ml, mh, run, c;
    int mismatches = 0;
    int tests_run = 0;
    ddcc_host_model host_u (.clk_in(clk_in), .rdata_in(rdata), .rvalid_in(rvalid),
        .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));
    ddcc_regs dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .wr_en_in(wr_en), .rd_en_in(rd_en),
        .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(rvalid),
        .window_compare_hold_enable_out(hold), .write_protect_bit_out(lock),
        .snapshot_read_location_out(snap), .int_ref_enable_out(ref_en),
        .voltage_output_shutdown_out(vsh), .current_output_shutdown_out(ish),
        .soft_reset_out(srst), .synchronous_output_load_out(gp[6]),
        .output_clear_trigger_out(gp[5]), .fault_dump_trigger_out(gp[4]),
        .protect_trigger_out(gp[3]), .single_row_readback_out(gp[2]),
        .nonvolatile_write_trigger_out(gp[1]), .nonvolatile_restore_trigger_out(gp[0]),
        .comparator_flag_clear_out(fc), .lower_margin_trigger_out(ml),
        .upper_margin_trigger_out(mh), .waveform_run_out(run));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    ////////////////////////////////////////
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        host_u.rd(a, d, v);
        `CHK(v, 1'b1)
        `CHK(d, e)
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // fields, every shutdown code, then each trigger, soft reset and the lock
    initial begin
        resetn_in = 1'b0;
        repeat (2) @(posedge clk_in);
        @(negedge clk_in) resetn_in = 1'b1;
        `CHK({vsh, ish, snap}, {4'hf, 2'b11, 8'h00})
        `CHK(lock, 1'b0)
        rchk(8'h1f, 16'h0fff);
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            host_u.wr(8'h1f, {2'b10, c[0], c[1], c, c[0], 6'h3f, c, c[1]});
            `CHK({hold, snap, ref_en, vsh, ish}, {8'h80, c[0], c[1], c, c, c[1], c[0]})
        end
        rchk(8'h1f, 16'hbfff);
        for (int b = 0; b < 8; b++) begin
            w = 16'h0001 << b;
            host_u.wr(8'h20, w);
            `CHK(gp, {w[7:6], w[4:0]})
            @(negedge clk_in);
            `CHK(gp, 7'h00)
        end
        rchk(8'h20, 16'h0000);
        host_u.wr(8'h21, 16'hf00f);
        `CHK({fc, ml, mh, run}, 8'hff)
        rchk(8'h21, 16'h1001);
        host_u.wr(8'h21, 16'h2004);
        `CHK({fc, ml, mh, run}, 8'h18)
        host_u.wr(8'h20, 16'h0900);
        `CHK(srst, 1'b0)
        host_u.wr(8'h20, 16'h0a08);
        `CHK({srst, gp}, 8'h80)
        rchk(8'h1f, 16'h0fff);
        host_u.wr(8'h1f, 16'h5000);
        `CHK(lock, 1'b1)
        host_u.wr(8'h21, 16'h0001);
        host_u.wr(8'h20, 16'h6008);
        `CHK({gp, run}, 9'h000)
        host_u.wr(8'h1f, 16'h0000);
        rchk(8'h1f, 16'h5000);
        host_u.unlock(16'h0000);
        `CHK(lock, 1'b0)
        rchk(8'h1f, 16'h1000);
        rchk(8'h30, 16'h0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
